// ===== rtl/bmf_pkg.sv
// bmf_pkg: constants, labels and carriers for the bus monitor formatter.
// assumes one hclk domain; nothing in here is clocked.
package bmf_pkg;
	localparam int TRK_MAX = 4; // most tracks one bus may spread over
	// frame sync and fill pattern
	localparam logic [23:0] FRM_SYNC = 24'hFAF320;
	localparam logic [15:0] FILL_INFO = 16'hAAAA;
	// content labels, bits 5..8 of a formatted word
	localparam logic [3:0] LBL_CMD_A = 4'hF;
	localparam logic [3:0] LBL_STS_A = 4'hE;
	localparam logic [3:0] LBL_DAT_A = 4'hD;
	localparam logic [3:0] LBL_ERR_A = 4'hC;
	localparam logic [3:0] LBL_CMD_B = 4'hB;
	localparam logic [3:0] LBL_STS_B = 4'hA;
	localparam logic [3:0] LBL_DAT_B = 4'h9;
	localparam logic [3:0] LBL_ERR_B = 4'h8;
	localparam logic [3:0] LBL_TIME_HI = 4'h7;
	localparam logic [3:0] LBL_TIME_LO = 4'h6;
	localparam logic [3:0] LBL_TIME_US = 4'h5;
	localparam logic [3:0] LBL_TIME_RSP = 4'h4;
	localparam logic [3:0] LBL_USER1 = 4'h3;
	localparam logic [3:0] LBL_USER2 = 4'h2;
	localparam logic [3:0] LBL_FILL = 4'h1;
	localparam logic [3:0] LBL_OVFL = 4'h0;
	localparam logic [3:0] LBL_CRC = LBL_USER2; // kept off the bus labels
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FLEN = 8'h04;
	localparam logic [7:0] REG_DIV = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	// frame length limits in words, sync included
	localparam logic [8:0] FLEN_MIN = 9'h081;
	localparam logic [8:0] FLEN_MAX = 9'h1FF;
	localparam logic [8:0] FLEN_RST = 9'h100;
	// half-bit divider reload: 40 MHz / 2 / (19 + 1) = 1 Mbit/s
	localparam logic [15:0] DIV_RST = 16'h0013;
	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam logic [14:0] RNRZ_SEED = 15'h7FFF;
	localparam logic [4:0] PHASE_LAST = 5'h17; // bit 24 of a word
	typedef enum logic [1:0] {KIND_CMD, KIND_STS, KIND_DAT} bmf_kind_t;
	// one word from the bus decoder: data bits then parity
	typedef struct packed {
		logic chan_b; // secondary channel
		bmf_kind_t kind; // from the sync type and message position
		logic first; // first command of a message
		logic err; // sync, manchester, gap or bit-count fault
		logic [16:0] bits; // bus bits 4..19, then parity bit 20
	} bmf_rx_t;
	typedef struct packed {
		logic [15:0] hi;
		logic [15:0] lo;
		logic [15:0] us;
	} bmf_time_t;
	typedef struct packed {
		logic [3:0] bus; // bus number minus one
		logic tag; // message time tagging
		logic rnrz; // 1 randomized nrz-l, 0 bi-phase-l
		logic crc; // frame check word
		logic time_en; // frame time words
		logic [1:0] tk; // track count minus one
		logic en; // run the frame engine
	} bmf_ctrl_t;
	localparam bmf_ctrl_t CTRL_RST = 11'h000;
endpackage : bmf_pkg

// ===== rtl/bmf_formatter.sv
// bmf_formatter: passive 1553 monitor words to spread-track pcm frames.
// assumes a same-clock bus decoder feeding rx_word and a same-clock time
// source; one instance per monitored bus, registers over ahb-lite.
//
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
module bmf_formatter
	import bmf_pkg::*;
#(
	parameter int FIFO_DEPTH = 16 // captured-word buffer, power of two
)
(
	input wire logic hclk, // system clock, 40 MHz
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // ahb slave select
	input wire logic [31:0] haddr, // ahb address
	input wire logic [1:0] htrans, // ahb transfer type
	input wire logic hwrite, // ahb write
	input wire logic [2:0] hsize, // ahb size, words only
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hready, // ahb bus ready
	output logic hreadyout, // ahb slave ready
	output logic hresp, // ahb response, always okay
	output logic [31:0] hrdata, // ahb read data
	input wire logic rx_valid, // one-cycle decoded word strobe
	input wire bmf_rx_t rx_word, // decoded bus word
	input wire bmf_time_t time_now, // running time
	output logic [TRK_MAX-1:0] trk_data, // coded pcm per track
	output logic [TRK_MAX-1:0] trk_clk // bit clock per track
);

	localparam int AW = $clog2(FIFO_DEPTH);

	// word spacing between tracks in bit times
	function automatic logic [4:0] trk_off(input logic [2:0] tk);
		case (tk)
			3'h1: trk_off = 5'h18;
			3'h2: trk_off = 5'h0C;
			3'h3: trk_off = 5'h08;
			default: trk_off = 5'h06;
		endcase
	endfunction : trk_off

	// crc-16, x16+x15+x2+1, msb first over the 16 info bits
	function automatic logic [15:0] crc16(input logic [15:0] c,
		input logic [15:0] d);
		logic fb;
		fb = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			fb = c[15] ^ d[i];
			c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
		end
		crc16 = c;
	endfunction : crc16

	// odd parity over data plus parity bit must come out set
	function automatic logic rx_bad(input bmf_rx_t r);
		rx_bad = r.err | ~(^r.bits);
	endfunction : rx_bad

	// build the 24-bit word for a captured bus word
	function automatic logic [23:0] fmt_rx(input bmf_rx_t r,
		input logic [3:0] bus);
		logic [3:0] lbl;
		lbl = r.chan_b ? LBL_DAT_B : LBL_DAT_A;
		if (rx_bad(r))
			lbl = r.chan_b ? LBL_ERR_B : LBL_ERR_A;
		else if (r.kind == KIND_CMD)
			lbl = r.chan_b ? LBL_CMD_B : LBL_CMD_A;
		else if (r.kind == KIND_STS)
			lbl = r.chan_b ? LBL_STS_B : LBL_STS_A;
		// parity in bit 0 is dropped, bus bit 4 goes to bit 9
		fmt_rx = {bus, lbl, r.bits[16:1]};
	endfunction : fmt_rx

	function automatic logic [8:0] flen_fit(input logic [8:0] v);
		if (v < FLEN_MIN)
			flen_fit = FLEN_MIN;
		else
			flen_fit = v; // 9 bits never pass FLEN_MAX
	endfunction : flen_fit

	bmf_ctrl_t ctrl_q;
	logic [8:0] flen_q;
	logic [15:0] div_q;
	logic wr_pend_q, rd_pend_q, hready_q, hresp_q;
	logic [7:0] acc_addr_q;
	logic [31:0] hrdata_q;
	logic [15:0] frames_q;
	logic [15:0] lost_q;
	logic [2:0] tk;
	logic addr_ok;

	assign tk = {1'b0, ctrl_q.tk} + 3'h1;
	assign addr_ok = hsel & hready & htrans[1];

	logic [23:0] mem [FIFO_DEPTH];
	logic [AW:0] wp_q, rp_q;
	logic full, empty, push, pop;
	logic [23:0] push_word, ld_word;
	logic [AW:0] fifo_cnt;
	assign empty = wp_q == rp_q;
	assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	assign fifo_cnt = wp_q - rp_q;

	// ahb address phase; reads wait one cycle so a write just ahead lands
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			acc_addr_q <= 8'h00;
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
		end
		else
		begin
			wr_pend_q <= addr_ok & hwrite;
			rd_pend_q <= addr_ok & ~hwrite;
			hready_q <= ~(addr_ok & ~hwrite);
			if (addr_ok)
				acc_addr_q <= haddr[7:0];
		end
	end

	// register writes in the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_q <= CTRL_RST;
			flen_q <= FLEN_RST;
			div_q <= DIV_RST;
		end
		else if (wr_pend_q)
		begin
			case (acc_addr_q)
				REG_CTRL: ctrl_q <= hwdata[10:0];
				REG_FLEN: flen_q <= flen_fit(hwdata[8:0]);
				REG_DIV: div_q <= hwdata[15:0];
				default: ;
			endcase
		end
	end

	// read data; unmapped offsets read zero
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_q <= 32'h00000000;
		else if (rd_pend_q)
		begin
			case (acc_addr_q)
				REG_CTRL: hrdata_q <= {21'h000000, ctrl_q};
				REG_FLEN: hrdata_q <= {23'h000000, flen_q};
				REG_DIV: hrdata_q <= {16'h0000, div_q};
				REG_STAT: hrdata_q <= {frames_q, lost_q[7:0],
					8'(fifo_cnt)};
				default: hrdata_q <= 32'h00000000;
			endcase
		end
	end
	assign hreadyout = hready_q;
	assign hresp = hresp_q;
	assign hrdata = hrdata_q;

	// capture side: only inputs from the bus decoder, no transmit path
	logic hold_vld_q, hold_tag_q, ovf_pend_q;
	logic [23:0] hold_q;
	logic [1:0] tag_cnt_q;
	bmf_time_t tag_time_q;
	logic rx_take;
	// the hold stays shut while tag words drain, so tag_time_q holds still
	assign rx_take = rx_valid & ~hold_vld_q & (tag_cnt_q == 2'h0);

	// push priority: overflow marker, pending time tags, held bus word
	always_comb
	begin
		push = 1'b0;
		push_word = hold_q;
		if (!full)
		begin
			if (ovf_pend_q)
			begin
				push = 1'b1;
				push_word = {ctrl_q.bus, LBL_OVFL, lost_q};
			end
			else if (tag_cnt_q != 2'h0)
			begin
				push = 1'b1;
				case (tag_cnt_q)
					2'h3: push_word = {ctrl_q.bus, LBL_TIME_HI, tag_time_q.hi};
					2'h2: push_word = {ctrl_q.bus, LBL_TIME_LO, tag_time_q.lo};
					default: push_word = {ctrl_q.bus, LBL_TIME_US,
						tag_time_q.us};
				endcase
			end
			else if (hold_vld_q)
				push = 1'b1;
		end
	end

	// one-word hold between decoder and buffer
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hold_vld_q <= 1'b0;
			hold_tag_q <= 1'b0;
			hold_q <= 24'h000000;
			tag_cnt_q <= 2'h0;
			tag_time_q <= '0;
		end
		else
		begin
			if (rx_take)
			begin
				hold_vld_q <= 1'b1;
				hold_q <= fmt_rx(rx_word, ctrl_q.bus);
				hold_tag_q <= ctrl_q.tag & rx_word.first &
					(rx_word.kind == KIND_CMD) & ~rx_bad(rx_word);
				tag_time_q <= time_now;
			end
			else if (push && !ovf_pend_q && tag_cnt_q == 2'h0)
				hold_vld_q <= 1'b0;
			// the tagged command leaves first, its three times next; only an overflow marker can cut in between
			if (push && !ovf_pend_q && tag_cnt_q == 2'h0 && hold_tag_q)
				tag_cnt_q <= 2'h3;
			else if (push && !ovf_pend_q && tag_cnt_q != 2'h0)
				tag_cnt_q <= tag_cnt_q - 2'h1;
		end
	end

	// lost words: a word that meets a busy hold is dropped and marked
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ovf_pend_q <= 1'b0;
			lost_q <= 16'h0000;
		end
		else
		begin
			if (rx_valid && !rx_take)
			begin
				ovf_pend_q <= 1'b1; // set beats the clear below
				if (lost_q != 16'hFFFF)
					lost_q <= lost_q + 16'h0001;
			end
			else if (push && ovf_pend_q)
				ovf_pend_q <= 1'b0;
		end
	end

	// word buffer between capture and frames
	always_ff @(posedge hclk)
	begin
		if (push)
			mem[wp_q[AW-1:0]] <= push_word;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wp_q <= '0;
			rp_q <= '0;
		end
		else
		begin
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
		end
	end

	// half-bit divider; bi-phase needs the mid-bit edge
	logic [15:0] div_cnt_q;
	logic half_q, half_en, bit_en, mid_en;
	assign half_en = ctrl_q.en && div_cnt_q == 16'h0000;
	assign bit_en = half_en & half_q;
	assign mid_en = half_en & ~half_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_cnt_q <= DIV_RST;
			half_q <= 1'b1;
		end
		else if (!ctrl_q.en)
		begin
			div_cnt_q <= 16'h0000;
			half_q <= 1'b1;
		end
		else
		begin
			div_cnt_q <= half_en ? div_q : div_cnt_q - 16'h0001;
			if (half_en)
				half_q <= ~half_q;
		end
	end

	// bit phase within a word period and word slot within a frame
	logic [4:0] phase_q, nphase, off;
	logic [8:0] slot_q, nslot;
	logic ld_any, ld_go, time_slot, crc_slot;
	logic [1:0] ld_idx;
	logic [10:0] gidx;
	logic [15:0] crc_q [TRK_MAX];
	bmf_time_t frm_time_q;

	assign off = trk_off(tk);
	assign nphase = (phase_q == PHASE_LAST) ? 5'h00 : phase_q + 5'h01;
	// one slot counter for all tracks keeps every frame the same length
	assign nslot = (nphase != 5'h00) ? slot_q :
		(slot_q >= flen_q - 9'h001) ? 9'h000 : slot_q + 9'h001;

	// track t takes its next word t*24/tk bits into the word period
	always_comb
	begin
		ld_any = 1'b0;
		ld_idx = 2'h0;
		for (int t = 0; t < TRK_MAX; t++)
		begin
			if (3'(t) < tk && nphase == 5'(t * int'(off)))
			begin
				ld_any = 1'b1;
				ld_idx = 2'(t);
			end
		end
	end
	assign ld_go = bit_en & ld_any;
	// position in the track-interleaved word order after sync
	assign gidx = 11'((int'(nslot) - 1) * int'(tk) + int'(ld_idx));
	assign time_slot = ctrl_q.time_en && nslot != 9'h000 &&
		gidx < 11'h003;
	assign crc_slot = ctrl_q.crc && nslot == flen_q - 9'h001;

	// choose the word for the loading track
	always_comb
	begin
		ld_word = {ctrl_q.bus, LBL_FILL, FILL_INFO};
		pop = 1'b0;
		if (nslot == 9'h000)
			ld_word = FRM_SYNC;
		else if (crc_slot)
			ld_word = {ctrl_q.bus, LBL_CRC, crc_q[ld_idx]};
		else if (time_slot)
		begin
			case (gidx[1:0])
				2'h0: ld_word = {ctrl_q.bus, LBL_TIME_HI, frm_time_q.hi};
				2'h1: ld_word = {ctrl_q.bus, LBL_TIME_LO, frm_time_q.lo};
				default: ld_word = {ctrl_q.bus, LBL_TIME_US, frm_time_q.us};
			endcase
		end
		else if (!empty)
		begin
			ld_word = mem[rp_q[AW-1:0]];
			pop = ld_go;
		end
	end

	// frame position, frame time and frame count
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			phase_q <= PHASE_LAST;
			slot_q <= 9'h000;
			frm_time_q <= '0;
			frames_q <= 16'h0000;
		end
		else if (!ctrl_q.en)
		begin
			phase_q <= PHASE_LAST; // next bit starts a fresh frame
			slot_q <= flen_q - 9'h001;
		end
		else if (bit_en)
		begin
			phase_q <= nphase;
			slot_q <= nslot;
			if (ld_any && ld_idx == 2'h0 && nslot == 9'h000)
			begin
				frm_time_q <= time_now;
				frames_q <= frames_q + 16'h0001;
			end
		end
	end

	// per-track check sequence over info bits, restarted by each sync
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int t = 0; t < TRK_MAX; t++)
				crc_q[t] <= CRC_INIT;
		end
		else if (ld_go)
		begin
			if (nslot == 9'h000)
				crc_q[ld_idx] <= CRC_INIT;
			else if (!crc_slot)
				crc_q[ld_idx] <= crc16(crc_q[ld_idx], ld_word[15:0]);
		end
	end

	// per-track serialiser and line coder
	logic sh_bit [TRK_MAX];
	for (genvar t = 0; t < TRK_MAX; t++)
	begin : g_trk
		logic [23:0] sh_q;
		logic [14:0] lfsr_q;
		logic bit_q, data_q, clk_q, ld_t, nb, scr, act;
		assign ld_t = ld_go && ld_idx == 2'(t);
		assign nb = ld_t ? ld_word[23] : sh_q[23];
		assign scr = nb ^ lfsr_q[14] ^ lfsr_q[13];
		assign act = 3'(t) < tk;
		assign sh_bit[t] = bit_q;
		always_ff @(posedge hclk or negedge hresetn)
		begin
			if (!hresetn)
			begin
				sh_q <= 24'h000000;
				lfsr_q <= RNRZ_SEED;
				bit_q <= 1'b0;
				data_q <= 1'b0;
				clk_q <= 1'b0;
			end
			else if (!ctrl_q.en)
			begin
				data_q <= 1'b0;
				clk_q <= 1'b0;
			end
			else if (bit_en)
			begin
				sh_q <= ld_t ? {ld_word[22:0], 1'b0} : {sh_q[22:0], 1'b0};
				bit_q <= nb;
				clk_q <= act;
				if (!act)
					data_q <= 1'b0;
				else if (ctrl_q.rnrz)
				begin
					data_q <= scr;
					lfsr_q <= {lfsr_q[13:0], scr};
				end
				else
					data_q <= nb; // bi-phase-l first half is the bit
			end
			else if (mid_en)
			begin
				clk_q <= 1'b0;
				if (act && !ctrl_q.rnrz)
					data_q <= ~bit_q;
			end
		end
		assign trk_data[t] = data_q;
		assign trk_clk[t] = clk_q;
	end

	// checks
	sync_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ld_go && nslot == 9'h000) |=> sh_bit[$past(ld_idx)] == 1'b1
		##1 sh_bit[$past(ld_idx, 2)] == 1'b1)
		else $error("frame does not open with sync");
	msb_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ld_go |=> sh_bit[$past(ld_idx)] == $past(ld_word[23]))
		else $error("word bit 1 not sent first");
	track_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ld_any |-> (3'(ld_idx) < tk) && (nphase == 5'(int'(ld_idx) *
		int'(off))))
		else $error("track load off its 24/tk slot");
	fill_word_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ld_go && empty && nslot != 9'h000 && !time_slot && !crc_slot)
		|-> ld_word[19:0] == {LBL_FILL, FILL_INFO} && !pop)
		else $error("fill word wrong");
	frame_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
		flen_q > 9'h080 && (!ctrl_q.en || slot_q < flen_q))
		else $error("frame length out of range");
	err_label_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(rx_take && rx_bad(rx_word)) |=> hold_q[19:16] ==
		($past(rx_word.chan_b) ? LBL_ERR_B : LBL_ERR_A))
		else $error("error word label wrong");
	bit_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rx_take |=> hold_q[15:0] == $past(rx_word.bits[16:1]) &&
		hold_q[23:20] == ctrl_q.bus)
		else $error("bus bits misplaced");
	time_tag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(push && hold_tag_q && tag_cnt_q == 2'h0 && !ovf_pend_q)
		|=> tag_cnt_q == 2'h3 ##[0:40] (push &&
		push_word[19:16] == LBL_TIME_HI))
		else $error("time tag missing after command");
	crc_word_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ld_go && crc_slot) |-> ld_word[19:0] == {LBL_CRC,
		crc_q[ld_idx]})
		else $error("check word not at frame end");
	ovf_mark_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(rx_valid && hold_vld_q) |=> ovf_pend_q)
		else $error("lost word not marked");

endmodule : bmf_formatter

// ===== verification/bmf_tape_model.sv
// bmf_tape_model: recorder stand-in on one track, recovers 24-bit words.
// assumes the track bit clock is high in the first half of each bit.
`timescale 1ns/10ps
module bmf_tape_model
	import bmf_pkg::*;
(
	input wire logic hclk, // system clock
	input wire logic rst_n, // restarts the sync search
	input wire logic rnrz, // 1 descramble rnrz-l
	input wire logic line_clk, // track bit clock
	input wire logic line_data, // coded track data
	output logic sync_seen, // pulse per sync word
	output logic word_valid, // pulse per other word
	output logic [23:0] word // last word, msb first
);
	logic clk_prev_q;
	logic locked_q;
	logic [4:0] cnt_q;
	logic [14:0] scr_q;
	logic [23:0] sh_q;
	logic bit_v;
	logic [23:0] nxt;
	// self-sync descrambler: first 15 bits after a restart are junk
	assign bit_v = rnrz ? line_data ^ scr_q[14] ^ scr_q[13] : line_data;
	assign nxt = {sh_q[22:0], bit_v};
	// no rate floor here, the bench keeps rnrz rates high
	always_ff @(posedge hclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clk_prev_q <= 1'b0;
			locked_q <= 1'b0;
			cnt_q <= 5'h00;
			scr_q <= 15'h0000;
			sh_q <= 24'h000000;
			sync_seen <= 1'b0;
			word_valid <= 1'b0;
			word <= 24'h000000;
		end
		else
		begin
			clk_prev_q <= line_clk;
			sync_seen <= 1'b0;
			word_valid <= 1'b0;
			if (line_clk && !clk_prev_q)
			begin
				sh_q <= nxt;
				scr_q <= {scr_q[13:0], line_data};
				if (!locked_q)
				begin
					locked_q <= (nxt == FRM_SYNC);
					sync_seen <= (nxt == FRM_SYNC);
					cnt_q <= 5'h00;
				end
				else if (cnt_q == PHASE_LAST)
				begin
					cnt_q <= 5'h00;
					word <= nxt;
					sync_seen <= (nxt == FRM_SYNC);
					word_valid <= (nxt != FRM_SYNC);
				end
				else
					cnt_q <= cnt_q + 5'h01;
			end
		end
	end
endmodule : bmf_tape_model

// ===== verification/testbench.sv
// testbench: ahb and word-strobe stimulus, four recorders on the tracks.
// assumes hready is the formatter's own hreadyout, single slave.
`timescale 1ns/10ps
module testbench
	import bmf_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rx_valid;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	bmf_rx_t rx_word, r;
	bmf_time_t time_now;
	logic [3:0] trk_data, trk_clk, sy, wv, got_s, got_w, bus_sel;
	logic [23:0] wd [4];
	logic [23:0] w1 [4];
	int t_sync [4];
	int n_errors, checked, cyc, slot, lost_exp, n, tk;
	logic chk_on, framed, mdl_rstn, rnrz_cfg;
	logic [23:0] exp_q [$];
	assign hready = hreadyout;
	bmf_formatter uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid),
		.rx_word(rx_word), .time_now(time_now), .trk_data(trk_data),
		.trk_clk(trk_clk));
	for (genvar g = 0; g < 4; g++)
	begin : g_rec
		bmf_tape_model rec (.hclk(hclk), .rst_n(mdl_rstn), .rnrz(rnrz_cfg),
			.line_clk(trk_clk[g]), .line_data(trk_data[g]),
			.sync_seen(sy[g]), .word_valid(wv[g]), .word(wd[g]));
	end
	// 40 MHz clock
	initial
	begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	// one single transfer, waits on hready with no assumed latency
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'b10;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic send(input bmf_rx_t w, input logic dup);
		@(posedge hclk);
		rx_word <= w;
		rx_valid <= 1'b1;
		if (dup)
			@(posedge hclk);
		@(posedge hclk);
		rx_valid <= 1'b0;
		repeat (60) @(posedge hclk);
	endtask : send
	function automatic logic [15:0] tv(input int i);
		return i == 0 ? time_now.hi : i == 1 ? time_now.lo : time_now.us;
	endfunction : tv
	// expected word from bus bits: parity dropped, odd parity or error
	function automatic logic [23:0] fmt(input bmf_rx_t w);
		logic [1:0] k;
		k = (w.err || !(^w.bits)) ? 2'b00 : 2'b11 - 2'(w.kind);
		return {bus_sel, 1'b1, ~w.chan_b, k, w.bits[16:1]};
	endfunction : fmt
	function automatic logic [31:0] ctrl(input int t, tm, ck, rz);
		bmf_ctrl_t c;
		c = '{bus: bus_sel, tag: 1'b1, rnrz: rz[0], crc: ck[0],
			time_en: tm[0], tk: t[1:0], en: 1'b1};
		return 32'(c);
	endfunction : ctrl
	function automatic logic [19:0] lead(input int t, input logic tm);
		return (tm && t < 3) ? {4'h7 - 4'(t), tv(t)} : {4'h1, 16'hAAAA};
	endfunction : lead
	task automatic word_chk(input int s, input logic [23:0] w);
		chk("bus_label", 32'(w[23:20]), 32'(bus_sel));
		if (s < 4)
			chk("frame_time", 32'(w[19:0]), 32'(lead(s - 1, 1'b1)));
		else if (s == 128)
			chk("check_label", 32'(w[19:16]), 32'(LBL_CRC));
		else if (w[19:16] == 4'h1)
			chk("fill_info", 32'(w[15:0]), 32'hAAAA);
		else if (w[19:16] == 4'h0)
			chk("overflow", 32'(w[15:0]), 32'(lost_exp));
		else if (exp_q.size() == 0)
			chk("extra_word", 32'(w), 32'h0);
		else
			chk("bus_word", 32'(w), 32'(exp_q.pop_front()));
	endtask : word_chk
	// recorder watch, track 0 frame check, timeout
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			n_errors++;
			summarize;
		end
		for (int t = 0; t < 4; t++)
		begin
			if (!mdl_rstn)
			begin
				got_s[t] <= 1'b0;
				got_w[t] <= 1'b0;
			end
			if (sy[t] && !got_s[t])
			begin
				got_s[t] <= 1'b1;
				t_sync[t] <= cyc;
			end
			if (wv[t] && got_s[t] && !got_w[t])
			begin
				got_w[t] <= 1'b1;
				w1[t] <= wd[t];
			end
		end
		if (chk_on && sy[0])
		begin
			if (framed)
				chk("frame_len", 32'(slot), 32'(FLEN_MIN) - 1);
			framed <= 1'b1;
			slot <= 0;
		end
		if (chk_on && framed && wv[0])
		begin
			slot <= slot + 1;
			word_chk(slot + 1, wd[0]);
		end
	end
	// main sequence
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		rx_valid = 1'b0;
		rx_word = '0;
		time_now = '0;
		mdl_rstn = 1'b0;
		rnrz_cfg = 1'b0;
		{chk_on, framed, got_s, got_w} = '0;
		{slot, cyc, n_errors, checked, lost_exp} = '0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		mdl_rstn <= 1'b1;
		hsel <= 1'b1;
		n = $urandom(32'hE2C8);
		bus_sel = 4'($urandom_range(14));
		time_now <= {16'($urandom), $urandom};
		ahb(0, REG_CTRL, 0);
		chk("ctrl_rst", rd, 32'(CTRL_RST));
		ahb(0, REG_FLEN, 0);
		chk("flen_rst", rd, 32'(FLEN_RST));
		ahb(0, REG_DIV, 0);
		chk("div_rst", rd, 32'(DIV_RST));
		ahb(0, 8'h10, 0);
		chk("unmapped", rd, 32'h0);
		ahb(1, REG_FLEN, 32'h10);
		ahb(0, REG_FLEN, 0);
		chk("flen_clamp", rd, 32'(FLEN_MIN));
		ahb(1, REG_DIV, 32'h0);
		ahb(1, REG_CTRL, ctrl(0, 1, 1, 0));
		chk_on <= 1'b1;
		for (int i = 0; i < 12; i++)
		begin
			r.chan_b = 1'($urandom);
			r.kind = bmf_kind_t'($urandom_range(2));
			r.first = (r.kind == KIND_CMD);
			r.err = ($urandom_range(3) == 0);
			r.bits = 17'($urandom);
			if (i == 0)
				r = '{1'b0, KIND_CMD, 1'b1, 1'b0, {16'h8001, 1'b1}};
			exp_q.push_back(fmt(r));
			if (r.first && !r.err && ^r.bits)
				for (int k = 0; k < 3; k++)
					exp_q.push_back({bus_sel, lead(k, 1'b1)});
			if (i == 11)
				lost_exp = 1;
			send(r, i == 11);
		end
		repeat (2 * 129 * 48 + 1000) @(posedge hclk);
		chk_on <= 1'b0;
		chk("drained", 32'(exp_q.size()), 32'h0);
		ahb(0, REG_STAT, 0);
		chk("lost_count", 32'(rd[15:8]), 32'h1);
		for (int i = 0; i < 3; i++)
		begin
			tk = i + 2;
			ahb(1, REG_CTRL, 32'h0);
			mdl_rstn <= 1'b0;
			rnrz_cfg <= (i == 1);
			@(posedge hclk);
			mdl_rstn <= 1'b1;
			ahb(1, REG_CTRL, ctrl(tk - 1, i > 0, 0, i == 1));
			n = 0;
			while (!(&(got_w | (4'hF << tk))) && n < 15000)
			begin
				@(posedge hclk);
				n++;
			end
			for (int t = 0; t < 4; t++)
				if (t >= tk)
					chk("idle_track", 32'({trk_clk[t], trk_data[t]}), 32'h0);
				else
				begin
					if (i != 1)
						chk("skew", 32'(t_sync[t] - t_sync[0]), 32'(t * 48 / tk));
					chk("lead_word", 32'(w1[t][19:0]), 32'(lead(t, i > 0)));
					chk("trk_bus", 32'(w1[t][23:20]), 32'(bus_sel));
				end
		end
		summarize;
	end
endmodule : testbench
